// ### verilog/msc_defines.svh
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

// ********
// register indices, byte address is four times the index
// ********
`define MSC_IDX_TIMER0_CONTROL 8'h02
`define MSC_IDX_POWER_DOWN_TRIGGER 8'h03
`define MSC_IDX_WATCHDOG_KICK 8'h04
`define MSC_IDX_PORT_A_UPPER_MODE 8'h05
`define MSC_IDX_PORT_A_LOWER_MODE 8'h06
`define MSC_IDX_PORT_B_UPPER_MODE 8'h07
`define MSC_IDX_PORT_B_LOWER_MODE 8'h08
`define MSC_IDX_OVERFLOW_FLAGS 8'h09
`define MSC_IDX_FIRST_PWM_DUTY 8'h12
`define MSC_IDX_SECOND_PWM_DUTY 8'h13
`define MSC_IDX_MISC_TIMER_PWM_CONTROL 8'h14
`define MSC_IDX_CLOCK_SELECT_CONTROL 8'h15
`define MSC_IDX_THIRD_PWM_DUTY 8'h16
`define MSC_IDX_TABLE_POINTER_HIGH 8'h17

// ********
// reset values
// ********
`define MSC_RST_PORT_A_UPPER 8'h15
`define MSC_RST_PORT_A_LOWER 8'h55
`define MSC_RST_PORT_B 8'h55
`define MSC_RST_CLOCK_SELECT 8'h03
`define MSC_RST_MISC 8'h01

// ********
// field positions
// ********
`define MSC_BIT_COMPARATOR_STATUS 3
`define MSC_BIT_SLOW_TICK_CLEAR 2
`define MSC_BIT_TIMER0_HALT 1
`define MSC_BIT_PWM_CLEAR_HOLD 0
`define MSC_BIT_SLOW_TICK_FLAG 6
`define MSC_BIT_TIMER0_FLAG 4
`define MSC_TP_HIGH_MSB 2

// ********
// axi responses and timing
// ********
`define MSC_RESP_OKAY 2'h0
`define MSC_RESP_DECERR 2'h3
`define MSC_INSTR_CYCLE_DIV 1'h1

`endif

// ### verilog/msc_pkg.sv
package msc_pkg;

   // clock select control fields, msb first
   typedef struct packed {
      logic slow_clock_select;
      logic fast_clock_select;
      logic general_bit;
      logic slow_clock_off;
      logic fast_clock_off;
      logic cpu_clock_source;
      logic [1:0] cpu_clock_divider;
   } msc_clk_cfg_t;

   // timer0 control fields
   typedef struct packed {
      logic timer0_edge_select;
      logic timer0_source_select;
      logic [3:0] timer0_divider;
   } msc_tm0_cfg_t;

   // port mode codes
   typedef enum logic [1:0] {
      MSC_MODE_OD_PULLUP = 2'h0,
      MSC_MODE_OD_FLOAT = 2'h1,
      MSC_MODE_CMOS = 2'h2,
      MSC_MODE_COMPARATOR = 2'h3
   } msc_pin_mode_t;

   // read channel state, one-hot
   typedef enum logic [1:0] {
      MSC_RD_IDLE = 2'b01,
      MSC_RD_RESP = 2'b10
   } msc_rd_state_t;

endpackage

// ### verilog/msc_regs.sv
// Behaviour
// - three read/write duty registers, reset zero
// - comparator level readable at misc bit three
// - slow-tick clear bit pulses, then self-clears
// - timer0 halt bit freezes timer0 counting
// - first pwm held cleared while bit set
// - slow clock select picks rc or crystal
// - fast clock select picks rc or crystal
// - slow clock off during power-down when set
// - fast clock off bit stops fast clock
// - cpu clock source slow or fast
// - cpu divider 16, 4, 2 or 1
// - three-bit table pointer high field
// - timer0 external edge rising or falling
// - timer0 source instruction cycle or pin
// - timer0 divider powers of two, max 256
// - any write with strobe bit zero set requests power-down
// - any write with strobe bit zero set restarts the watchdog
// - two-bit pin mode codes per port pin
// - port a upper mode, pin four pull-up
// - port a lower mode, pin three pull-up
// - port b lower mode, code 11 comparator input
// - slow-tick overflow flag, write zero clears
// - timer0 overflow flag, write zero clears
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "msc_defines.svh"

module msc_regs #(
   parameter int DATA_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic comparator_output,
   input wire logic timer0_external_clock_pin,
   input wire logic pa4_ext_osc,
   input wire logic pa3_ext_osc,
   input wire logic slow_tick_overflow,
   input wire logic timer0_overflow,
   output logic [DATA_W-1:0] first_pwm_duty,
   output logic [DATA_W-1:0] second_pwm_duty,
   output logic [DATA_W-1:0] third_pwm_duty,
   output logic first_pwm_clear_hold,
   output logic slow_tick_timer_clear,
   output logic timer0_halt,
   output msc_pkg::msc_clk_cfg_t clock_cfg,
   output msc_pkg::msc_tm0_cfg_t timer0_cfg,
   output logic system_clock_en,
   output logic instruction_cycle_en,
   output logic timer0_tick,
   output logic [2:0] table_pointer_high,
   output logic power_down_request,
   output logic watchdog_restart,
   output logic [7:0] port_a_upper_mode,
   output logic [7:0] port_a_lower_mode,
   output logic [7:0] port_b_upper_mode,
   output logic [7:0] port_b_lower_mode,
   output logic [7:0] port_a_pullup_en,
   output logic [7:0] port_b_pullup_en,
   output logic [3:0] port_b_comparator_in,
   output logic slow_tick_overflow_flag,
   output logic timer0_overflow_flag
);
   import msc_pkg::*;

   // ********
   // helper functions
   // ********

   // last count of the cpu clock divider
   function automatic logic [3:0] cpu_last(input logic [1:0] code);
      case (code)
         2'h0: cpu_last = 4'hF;
         2'h1: cpu_last = 4'h3;
         2'h2: cpu_last = 4'h1;
         default: cpu_last = 4'h0;
      endcase
   endfunction

   // last count of the timer0 divider
   function automatic logic [7:0] tm0_last(input logic [3:0] code);
      logic [7:0] ratio;
      ratio = 8'h01 << code[2:0];
      if (code[3]) begin
         tm0_last = 8'hFF;
      end else begin
         tm0_last = ratio - 8'h01;
      end
   endfunction

   // pull-up on for mode 00, oscillator pins are masked where this is called
   function automatic logic [3:0] pullups(input logic [7:0] mode);
      logic [3:0] pu;
      pu = 4'h0;
      for (int i = 0; i < 4; i++) begin
         pu[i] = (mode[2*i +: 2] == MSC_MODE_OD_PULLUP);
      end
      pullups = pu;
   endfunction

   // ********
   // axi4-lite slave
   // ********
   logic aw_full_q, w_full_q;
   logic [7:0] aw_idx_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic do_write;
   msc_rd_state_t rd_state_q;

   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

   // write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_idx_q <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_q <= 1'b1;
         aw_idx_q <= {2'h0, s_axi_awaddr[7:2]};
         s_axi_awready <= 1'b0;
      end else begin
         if (do_write) begin
            aw_full_q <= 1'b0;
         end
         s_axi_awready <= !aw_full_q && !s_axi_bvalid;
      end
   end

   // write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q <= 1'b0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_q <= 1'b1;
         wdata_q <= s_axi_wdata[7:0];
         wstrb0_q <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else begin
         if (do_write) begin
            w_full_q <= 1'b0;
         end
         s_axi_wready <= !w_full_q && !s_axi_bvalid;
      end
   end

   // write response, unmapped index answers decode error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MSC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(aw_idx_q) ? `MSC_RESP_OKAY : `MSC_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // true for every index that answers okay, other indices answer decode error
   function automatic logic mapped(input logic [7:0] idx);
      mapped = (idx >= `MSC_IDX_TIMER0_CONTROL && idx <= `MSC_IDX_OVERFLOW_FLAGS)
         || (idx >= `MSC_IDX_FIRST_PWM_DUTY && idx <= `MSC_IDX_TABLE_POINTER_HIGH);
   endfunction

   // register write strobe for one index
   function automatic logic wr_hit(input logic [7:0] idx, input logic [7:0] sel,
                                   input logic go, input logic lane);
      wr_hit = go && lane && (idx == sel);
   endfunction

   logic wr_tm0, wr_pd, wr_wd, wr_pau, wr_pal, wr_pbu, wr_pbl, wr_flag;
   logic wr_d0, wr_d1, wr_d2, wr_misc, wr_clk, wr_tp;
   assign wr_tm0 = wr_hit(aw_idx_q, `MSC_IDX_TIMER0_CONTROL, do_write, wstrb0_q);
   assign wr_pd = wr_hit(aw_idx_q, `MSC_IDX_POWER_DOWN_TRIGGER, do_write, wstrb0_q);
   assign wr_wd = wr_hit(aw_idx_q, `MSC_IDX_WATCHDOG_KICK, do_write, wstrb0_q);
   assign wr_pau = wr_hit(aw_idx_q, `MSC_IDX_PORT_A_UPPER_MODE, do_write, wstrb0_q);
   assign wr_pal = wr_hit(aw_idx_q, `MSC_IDX_PORT_A_LOWER_MODE, do_write, wstrb0_q);
   assign wr_pbu = wr_hit(aw_idx_q, `MSC_IDX_PORT_B_UPPER_MODE, do_write, wstrb0_q);
   assign wr_pbl = wr_hit(aw_idx_q, `MSC_IDX_PORT_B_LOWER_MODE, do_write, wstrb0_q);
   assign wr_flag = wr_hit(aw_idx_q, `MSC_IDX_OVERFLOW_FLAGS, do_write, wstrb0_q);
   assign wr_d0 = wr_hit(aw_idx_q, `MSC_IDX_FIRST_PWM_DUTY, do_write, wstrb0_q);
   assign wr_d1 = wr_hit(aw_idx_q, `MSC_IDX_SECOND_PWM_DUTY, do_write, wstrb0_q);
   assign wr_d2 = wr_hit(aw_idx_q, `MSC_IDX_THIRD_PWM_DUTY, do_write, wstrb0_q);
   assign wr_misc = wr_hit(aw_idx_q, `MSC_IDX_MISC_TIMER_PWM_CONTROL, do_write, wstrb0_q);
   assign wr_clk = wr_hit(aw_idx_q, `MSC_IDX_CLOCK_SELECT_CONTROL, do_write, wstrb0_q);
   assign wr_tp = wr_hit(aw_idx_q, `MSC_IDX_TABLE_POINTER_HIGH, do_write, wstrb0_q);

   // ********
   // stored registers
   // ********

   // pwm duty registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_pwm_duty <= '0;
         second_pwm_duty <= '0;
         third_pwm_duty <= '0;
      end else begin
         if (wr_d0) first_pwm_duty <= wdata_q[DATA_W-1:0];
         if (wr_d1) second_pwm_duty <= wdata_q[DATA_W-1:0];
         if (wr_d2) third_pwm_duty <= wdata_q[DATA_W-1:0];
      end
   end

   // misc control bits, only bits 2..0 writable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer0_halt <= 1'b0;
         first_pwm_clear_hold <= 1'(`MSC_RST_MISC);
         slow_tick_timer_clear <= 1'b0;
      end else begin
         slow_tick_timer_clear <= wr_misc && wdata_q[`MSC_BIT_SLOW_TICK_CLEAR];
         if (wr_misc) begin
            timer0_halt <= wdata_q[`MSC_BIT_TIMER0_HALT];
            first_pwm_clear_hold <= wdata_q[`MSC_BIT_PWM_CLEAR_HOLD];
         end
      end
   end

   // clock selection and table pointer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_cfg <= `MSC_RST_CLOCK_SELECT;
         table_pointer_high <= 3'h0;
      end else begin
         if (wr_clk) clock_cfg <= wdata_q;
         if (wr_tp) table_pointer_high <= wdata_q[`MSC_TP_HIGH_MSB:0];
      end
   end

   // write-only timer0 control and port modes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer0_cfg <= '0;
         port_a_upper_mode <= `MSC_RST_PORT_A_UPPER;
         port_a_lower_mode <= `MSC_RST_PORT_A_LOWER;
         port_b_upper_mode <= `MSC_RST_PORT_B;
         port_b_lower_mode <= `MSC_RST_PORT_B;
      end else begin
         if (wr_tm0) timer0_cfg <= wdata_q[5:0];
         if (wr_pau) port_a_upper_mode <= wdata_q;
         if (wr_pal) port_a_lower_mode <= wdata_q;
         if (wr_pbu) port_b_upper_mode <= wdata_q;
         if (wr_pbl) port_b_lower_mode <= wdata_q;
      end
   end

   // write-triggered pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_down_request <= 1'b0;
         watchdog_restart <= 1'b0;
      end else begin
         power_down_request <= wr_pd;
         watchdog_restart <= wr_wd;
      end
   end

   // overflow flags, a set wins over a clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_tick_overflow_flag <= 1'b0;
         timer0_overflow_flag <= 1'b0;
      end else begin
         if (slow_tick_overflow) begin
            slow_tick_overflow_flag <= 1'b1;
         end else if (wr_flag && !wdata_q[`MSC_BIT_SLOW_TICK_FLAG]) begin
            slow_tick_overflow_flag <= 1'b0;
         end
         if (timer0_overflow) begin
            timer0_overflow_flag <= 1'b1;
         end else if (wr_flag && !wdata_q[`MSC_BIT_TIMER0_FLAG]) begin
            timer0_overflow_flag <= 1'b0;
         end
      end
   end

   // ********
   // pin synchronisers
   // ********
   logic [2:0] cmp_sync_q, tck_sync_q;
   logic cmp_level_q, tck_level_q;

   // three stages, level moves once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_sync_q <= 3'h0;
         tck_sync_q <= 3'h0;
         cmp_level_q <= 1'b0;
         tck_level_q <= 1'b0;
      end else begin
         cmp_sync_q <= {cmp_sync_q[1:0], comparator_output};
         tck_sync_q <= {tck_sync_q[1:0], timer0_external_clock_pin};
         if (cmp_sync_q[1] == cmp_sync_q[2]) cmp_level_q <= cmp_sync_q[2];
         if (tck_sync_q[1] == tck_sync_q[2]) tck_level_q <= tck_sync_q[2];
      end
   end

   // ********
   // derived pin controls
   // ********
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_a_pullup_en <= 8'h00;
         port_b_pullup_en <= 8'h00;
         port_b_comparator_in <= 4'h0;
      end else begin
         // oscillator pins lose their pull-up
         port_a_pullup_en <= {pullups(port_a_upper_mode) & {3'h7, !pa4_ext_osc},
            pullups(port_a_lower_mode) & {!pa3_ext_osc, 3'h7}};
         port_b_pullup_en <= {pullups(port_b_upper_mode), pullups(port_b_lower_mode)};
         for (int i = 0; i < 4; i++) begin
            port_b_comparator_in[i] <= port_b_lower_mode[2*i +: 2] == MSC_MODE_COMPARATOR;
         end
      end
   end

   // ********
   // system clock and timer0 prescalers
   // ********
   logic [3:0] sys_cnt_q;
   logic instr_phase_q;
   logic [7:0] tm0_cnt_q;
   logic tck_prev_q;
   logic tm0_src_tick;

   // system clock enable from the cpu divider, instruction cycle is half
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_cnt_q <= 4'h0;
         system_clock_en <= 1'b0;
         instr_phase_q <= 1'b0;
         instruction_cycle_en <= 1'b0;
      end else begin
         system_clock_en <= 1'b0;
         instruction_cycle_en <= 1'b0;
         if (sys_cnt_q >= cpu_last(clock_cfg.cpu_clock_divider)) begin
            sys_cnt_q <= 4'h0;
            system_clock_en <= 1'b1;
            instr_phase_q <= instr_phase_q ^ `MSC_INSTR_CYCLE_DIV;
            instruction_cycle_en <= instr_phase_q;
         end else begin
            sys_cnt_q <= sys_cnt_q + 4'h1;
         end
      end
   end

   // selected edge of the external pin or the instruction cycle
   assign tm0_src_tick = timer0_cfg.timer0_source_select ?
      ((tck_prev_q != tck_level_q) && (tck_level_q ^ timer0_cfg.timer0_edge_select))
      : instruction_cycle_en;

   // timer0 prescaler, frozen while halted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tck_prev_q <= 1'b0;
         tm0_cnt_q <= 8'h00;
         timer0_tick <= 1'b0;
      end else begin
         tck_prev_q <= tck_level_q;
         timer0_tick <= 1'b0;
         if (tm0_src_tick && !timer0_halt) begin
            if (tm0_cnt_q >= tm0_last(timer0_cfg.timer0_divider)) begin
               tm0_cnt_q <= 8'h00;
               timer0_tick <= 1'b1;
            end else begin
               tm0_cnt_q <= tm0_cnt_q + 8'h01;
            end
         end
      end
   end

   // ********
   // read channel
   // ********
   logic [7:0] rd_byte;
   logic [7:0] ar_idx;
   assign ar_idx = {2'h0, s_axi_araddr[7:2]};

   // read mux, write-only registers read zero
   always_comb begin
      case (ar_idx)
         `MSC_IDX_FIRST_PWM_DUTY: rd_byte = 8'(first_pwm_duty);
         `MSC_IDX_SECOND_PWM_DUTY: rd_byte = 8'(second_pwm_duty);
         `MSC_IDX_THIRD_PWM_DUTY: rd_byte = 8'(third_pwm_duty);
         `MSC_IDX_MISC_TIMER_PWM_CONTROL: rd_byte = {4'h0, cmp_level_q,
            slow_tick_timer_clear, timer0_halt, first_pwm_clear_hold};
         `MSC_IDX_CLOCK_SELECT_CONTROL: rd_byte = clock_cfg;
         `MSC_IDX_TABLE_POINTER_HIGH: rd_byte = {5'h00, table_pointer_high};
         `MSC_IDX_OVERFLOW_FLAGS: rd_byte = {1'b0, slow_tick_overflow_flag, 1'b0,
            timer0_overflow_flag, 4'h0};
         default: rd_byte = 8'h00;
      endcase
   end

   // one read at a time, answer one cycle after acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= MSC_RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `MSC_RESP_OKAY;
      end else begin
         case (rd_state_q)
            MSC_RD_IDLE: begin
               s_axi_arready <= 1'b1;
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= {24'h00_0000, rd_byte};
                  s_axi_rresp <= mapped(ar_idx) ? `MSC_RESP_OKAY : `MSC_RESP_DECERR;
                  rd_state_q <= MSC_RD_RESP;
               end
            end
            MSC_RD_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state_q <= MSC_RD_IDLE;
               end
            end
            default: rd_state_q <= MSC_RD_IDLE;
         endcase
      end
   end

endmodule

// ### tb/msc_regs_checker.sv
`timescale 1ns/10ps
// ********
// port relations of the register bank
// ********
module msc_regs_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic slow_tick_timer_clear,
   input wire logic timer0_halt,
   input wire logic timer0_tick,
   input wire logic power_down_request,
   input wire logic watchdog_restart,
   input wire logic slow_tick_overflow,
   input wire logic timer0_overflow,
   input wire logic slow_tick_overflow_flag,
   input wire logic timer0_overflow_flag
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write halves taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp_up;
      ##[1:3] s_axi_bvalid;
   endsequence
   a_write_answered: assert property (s_wr_taken |-> s_resp_up)
      else $error("write response missing");
   a_b_blocks_aw: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   a_r_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0)
      else $error("read channel misbehaves");
   a_clear_self_ends: assert property (
      slow_tick_timer_clear |=> !slow_tick_timer_clear) else $error("clear pulse too long");
   a_halt_stops_tick: assert property (
      timer0_halt && $past(timer0_halt) |-> !timer0_tick) else $error("tick while halted");
   a_pd_single_pulse: assert property (
      power_down_request |=> !power_down_request) else $error("power-down pulse too long");
   a_wdt_single_pulse: assert property (
      watchdog_restart |=> !watchdog_restart) else $error("watchdog pulse too long");
   a_slow_flag_set: assert property (
      slow_tick_overflow |=> slow_tick_overflow_flag) else $error("slow flag not set");
   a_t0_flag_set: assert property (
      timer0_overflow |=> timer0_overflow_flag) else $error("timer0 flag not set");
endmodule

bind msc_regs msc_regs_checker i_msc_regs_checker (.*);

// ### tb/msc_host_model.sv
`timescale 1ns/10ps
// ********
// cpu side bus master
// ********
module msc_host_model (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // idle bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // one write, halves released as each is taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= {idx[5:0], 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   // one read
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= {idx[5:0], 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
// ********
// register bank bench
// ********
module tb_top;
   import msc_pkg::*;
   logic aclk, aresetn, comparator_output, timer0_external_clock_pin;
   logic pa4_ext_osc, pa3_ext_osc, slow_tick_overflow, timer0_overflow;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, port_b_comparator_in;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] first_pwm_duty, second_pwm_duty, third_pwm_duty, port_a_upper_mode;
   logic [7:0] port_a_lower_mode, port_b_upper_mode, port_b_lower_mode;
   logic [7:0] port_a_pullup_en, port_b_pullup_en;
   logic first_pwm_clear_hold, slow_tick_timer_clear, timer0_halt, system_clock_en;
   logic instruction_cycle_en, timer0_tick, power_down_request, watchdog_restart;
   logic slow_tick_overflow_flag, timer0_overflow_flag;
   logic [2:0] table_pointer_high;
   msc_clk_cfg_t clock_cfg;
   msc_tm0_cfg_t timer0_cfg;
   logic [31:0] rv;
   logic [1:0] rr;
   int n_errors = 0;
   int checks = 0;
   int n_sys, n_ins, n_tick, n_clr, n_pd, n_wdt;
   int dv[4] = '{16, 4, 2, 1};
   msc_regs i_msc_regs (.*);
   msc_host_model i_msc_host_model (.*);
   // clock
   initial begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end
   // pulse counters, sampled mid-cycle
   always @(negedge aclk) begin
      n_sys += (system_clock_en === 1'h1);
      n_ins += (instruction_cycle_en === 1'h1);
      n_tick += (timer0_tick === 1'h1);
      n_clr += (slow_tick_timer_clear === 1'h1);
      n_pd += (power_down_request === 1'h1);
      n_wdt += (watchdog_restart === 1'h1);
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [33:0] g, e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      i_msc_host_model.wr(idx, d, rr);
      chk(rr, 2'h0);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [31:0] e);
      i_msc_host_model.rd(idx, rv, rr);
      chk({rr, rv}, {2'h0, e});
   endtask
   task automatic cnt(input int n);
      {n_sys, n_ins, n_tick, n_clr, n_pd, n_wdt} = '0;
      repeat (n) @(posedge aclk);
   endtask
   task automatic t_reset;
      chk(first_pwm_clear_hold, 1'h1);
      chk(clock_cfg, 8'h03);
      chk({port_a_upper_mode, port_a_lower_mode, port_b_upper_mode, port_b_lower_mode},
          32'h15555555);
      rc(8'h12, 0);
      rc(8'h16, 0);
      rc(8'h14, 8'h01);
      rc(8'h17, 0);
      rc(8'h05, 0);
   endtask
   task automatic t_duty;
      wr(8'h12, 8'hA5);
      wr(8'h13, 8'h5A);
      wr(8'h16, 8'hC3);
      wr(8'h17, 8'hFF);
      chk({first_pwm_duty, second_pwm_duty, third_pwm_duty}, 24'hA55AC3);
      rc(8'h13, 8'h5A);
      rc(8'h17, 8'h07);
      chk(table_pointer_high, 3'h7);
   endtask
   task automatic t_misc;
      wr(8'h14, 8'h00);
      cnt(16);
      chk(n_tick, 8);
      n_clr = 0;
      wr(8'h14, 8'hFE);
      repeat (4) @(posedge aclk);
      chk(n_clr, 1);
      rc(8'h14, 8'h02);
      chk({first_pwm_clear_hold, timer0_halt}, 2'h1);
      cnt(16);
      chk(n_tick, 0);
      wr(8'h14, 8'h00);
      comparator_output <= 1'h1;
      repeat (8) @(posedge aclk);
      rc(8'h14, 8'h08);
   endtask
   task automatic t_clk;
      logic [7:0] v;
      for (int c = 0; c < 4; c++) begin
         v = ((c % 2) ? 8'hA4 : 8'h58) | 8'(c);
         wr(8'h15, v);
         chk(clock_cfg, v);
         repeat (32) @(posedge aclk);
         cnt(64);
         chk(n_sys, 64 / dv[c]);
         chk(n_ins, 32 / dv[c]);
      end
      wr(8'h15, 8'h03);
   endtask
   task automatic t_tm0;
      logic [3:0] cd[5] = '{4'h0, 4'h3, 4'h7, 4'h8, 4'hF};
      for (int i = 0; i < 5; i++) begin
         wr(8'h02, {4'h0, cd[i]});
         chk(timer0_cfg, cd[i]);
         repeat (16) @(posedge aclk);
         cnt(1024);
         chk(n_tick, 512 / (cd[i][3] ? 256 : (1 << cd[i])));
      end
      for (int e = 0; e < 2; e++) begin
         wr(8'h02, e ? 8'h30 : 8'h10);
         cnt(8);
         repeat (4) begin
            timer0_external_clock_pin <= 1'h1;
            repeat (8) @(posedge aclk);
            timer0_external_clock_pin <= 1'h0;
            repeat (8) @(posedge aclk);
         end
         repeat (8) @(posedge aclk);
         chk(n_tick, 4);
      end
   endtask
   task automatic t_pulse;
      n_pd = 0;
      n_wdt = 0;
      wr(8'h03, 8'h5A);
      wr(8'h04, 8'h00);
      repeat (4) @(posedge aclk);
      chk({n_pd[7:0], n_wdt[7:0]}, 16'h0101);
   endtask
   task automatic t_ports;
      pa4_ext_osc <= 1'h1;
      pa3_ext_osc <= 1'h1;
      wr(8'h05, 8'h00);
      wr(8'h06, 8'h00);
      wr(8'h07, 8'h00);
      wr(8'h08, 8'hE4);
      repeat (4) @(posedge aclk);
      chk({port_a_upper_mode, port_a_lower_mode, port_b_upper_mode, port_b_lower_mode},
          32'h000000E4);
      chk({port_a_pullup_en, port_b_pullup_en}, 16'hE7F1);
      chk(port_b_comparator_in, 4'h8);
      rc(8'h08, 0);
   endtask
   task automatic t_flags;
      slow_tick_overflow <= 1'h1;
      timer0_overflow <= 1'h1;
      @(posedge aclk);
      slow_tick_overflow <= 1'h0;
      timer0_overflow <= 1'h0;
      rc(8'h09, 8'h50);
      chk({slow_tick_overflow_flag, timer0_overflow_flag}, 2'h3);
      wr(8'h09, 8'hFF);
      rc(8'h09, 8'h50);
      wr(8'h09, 8'hEF);
      rc(8'h09, 8'h40);
      wr(8'h09, 8'h00);
      rc(8'h09, 0);
      i_msc_host_model.rd(8'h0A, rv, rr);
      chk({rr, rv}, {2'h3, 32'h0});
      i_msc_host_model.wr(8'h20, 8'h11, rr);
      chk(rr, 2'h3);
   endtask
   // main sequence
   initial begin
      {aresetn, comparator_output, timer0_external_clock_pin, pa4_ext_osc} = '0;
      {pa3_ext_osc, slow_tick_overflow, timer0_overflow} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      t_reset();
      t_duty();
      t_misc();
      t_clk();
      t_tm0();
      t_pulse();
      t_ports();
      t_flags();
      give_verdict();
   end
   // watchdog
   initial begin
      #2000000;
      n_errors++;
      give_verdict();
   end
endmodule
